//--- cpu_interrupt_sequencer.sv
// interrupt sequencer: flag capture, arbitration, stacking, vectoring, return
// Function
// - capture event flags at each instruction cycle start
// - pending flag needs matching enable bit
// - arbitrate pending enabled requests during the cycle
// - interrupt only above current priority level
// - stack program counter and state word low byte
// - load accepted priority into the state word
// - software may lower level; clear flags first
// - trap level bit clear except during traps
// - return pops program counter and state word low byte
// - alternate table follows primary, same layout
// - select bit routes all vectors to alternate table
// - one-level shadow of flags and four registers
// - three edge-sensitive external inputs
// - per-input polarity bit selects edge direction
// - qualifying request wakes a sleeping processor
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_sequencer (
    // clock and reset
    input  wire logic                                        mclk,
    input  wire logic                                        arst_n,
    // instruction timing
    input  wire logic                                        instr_cycle_start,
    // event sources
    input  wire logic [irq_seq_pkg::NUM_SRC-1:0]             periph_events,
    input  wire logic [irq_seq_pkg::EXT_COUNT-1:0]           ext_irq_inputs,
    input  wire logic [irq_seq_pkg::EXT_COUNT-1:0]           ext_edge_select_bits,
    // software controls
    input  wire logic [irq_seq_pkg::NUM_SRC-1:0]             flag_clear,
    input  wire logic [irq_seq_pkg::NUM_SRC-1:0]             interrupt_enable_regs,
    input  wire logic [irq_seq_pkg::NUM_SRC*irq_seq_pkg::PRIO_W-1:0] src_priority,
    input  wire logic                                        alt_table_select,
    input  wire logic                                        state_word_wr,
    input  wire logic [irq_seq_pkg::WORD_W-1:0]              state_word_wr_data,
    input  wire logic                                        core_ctrl_wr,
    input  wire logic [irq_seq_pkg::WORD_W-1:0]              core_ctrl_wr_data,
    // processor core
    input  wire logic                                        trap_active,
    input  wire logic                                        sleep_or_idle,
    input  wire logic [irq_seq_pkg::PC_W-1:0]                pc_current,
    input  wire logic                                        return_from_handler_op,
    input  wire logic                                        stack_pop_valid,
    input  wire logic [irq_seq_pkg::WORD_W-1:0]              stack_pop_data,
    input  wire logic                                        shadow_save_op,
    input  wire logic                                        shadow_restore_op,
    input  wire logic [irq_seq_pkg::WREG_W-1:0]              work_regs_live,
    // status
    output logic      [irq_seq_pkg::NUM_SRC-1:0]             interrupt_flag_regs,
    output logic      [irq_seq_pkg::WORD_W-1:0]              proc_state_word,
    output logic      [irq_seq_pkg::WORD_W-1:0]              core_control_reg,
    output logic                                             busy,
    output logic                                             wake_req,
    // stack traffic
    output logic                                             stack_push_valid,
    output logic      [irq_seq_pkg::WORD_W-1:0]              stack_push_data,
    output logic                                             stack_pop_req,
    // vector fetch and return
    output logic                                             vector_valid,
    output logic      [irq_seq_pkg::PC_W-1:0]                vector_addr,
    output logic      [irq_seq_pkg::SRC_W-1:0]               vector_src,
    output logic                                             pc_restore_valid,
    output logic      [irq_seq_pkg::PC_W-1:0]                pc_restore,
    // shadow restore of working registers
    output logic                                             work_regs_restore_valid,
    output logic      [irq_seq_pkg::WREG_W-1:0]              work_regs_restore
);
    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        irq_seq_pkg::seq_state_t              fsm;
        logic [irq_seq_pkg::NUM_SRC-1:0]      flags;
        logic [irq_seq_pkg::NUM_SRC-1:0]      ev_latch;
        logic [irq_seq_pkg::WORD_W-1:0]       sw;
        logic [irq_seq_pkg::WORD_W-1:0]       core_ctrl;
        logic                                 best_valid;
        logic [irq_seq_pkg::PRIO_W-1:0]       best_prio;
        logic [irq_seq_pkg::SRC_W-1:0]        best_src;
        logic [irq_seq_pkg::PRIO_W-1:0]       take_prio;
        logic [irq_seq_pkg::SRC_W-1:0]        take_src;
        logic                                 push_valid;
        logic [irq_seq_pkg::WORD_W-1:0]       push_data;
        logic                                 vec_valid;
        logic [irq_seq_pkg::PC_W-1:0]         vec_addr;
        logic [irq_seq_pkg::SRC_W-1:0]        vec_src;
        logic [irq_seq_pkg::PC_HI_W-1:0]      pop_pc_hi;
        logic                                 pc_rst_valid;
        logic [irq_seq_pkg::PC_W-1:0]         pc_rst;
        logic                                 wake;
    } ctl_t;

    ctl_t cur;
    ctl_t next_cur;

    logic [irq_seq_pkg::EXT_COUNT-1:0]    ext_pulse;
    logic [irq_seq_pkg::NUM_SRC-1:0]      events_all;
    logic [irq_seq_pkg::SHADOW_W-1:0]     shadow_live;
    logic [irq_seq_pkg::SHADOW_W-1:0]     shadow_copy;
    logic                                 shadow_rvalid;
    logic [irq_seq_pkg::LEVEL_W-1:0]      cur_level;
    logic                                 take_now;
    logic                                 arb_valid;
    logic [irq_seq_pkg::PRIO_W-1:0]       arb_prio;
    logic [irq_seq_pkg::SRC_W-1:0]        arb_src;
    logic [irq_seq_pkg::PRIO_W-1:0]       p;
    logic [irq_seq_pkg::PC_W-1:0]         table_base;

    // -------------------------------------------------------------------------
    // external inputs
    // -------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < irq_seq_pkg::EXT_COUNT; g++) begin : gen_ext
            ext_edge_detect u_edge (
                .mclk       (mclk),
                .arst_n     (arst_n),
                .pin        (ext_irq_inputs[g]),
                .falling_sel(ext_edge_select_bits[g]),
                .edge_pulse (ext_pulse[g])
            );
        end
    endgenerate

    always_comb begin
        events_all = periph_events;
        events_all[irq_seq_pkg::EXT_SRC_BASE +: irq_seq_pkg::EXT_COUNT] =
            periph_events[irq_seq_pkg::EXT_SRC_BASE +: irq_seq_pkg::EXT_COUNT] | ext_pulse;
    end

    // -------------------------------------------------------------------------
    // shadow context
    // -------------------------------------------------------------------------
    assign shadow_live = {cur.sw[irq_seq_pkg::SW_DC], cur.sw[irq_seq_pkg::SW_N],
                          cur.sw[irq_seq_pkg::SW_OV], cur.sw[irq_seq_pkg::SW_Z],
                          cur.sw[irq_seq_pkg::SW_C], work_regs_live};

    shadow_context u_shadow (
        .mclk         (mclk),
        .arst_n       (arst_n),
        .save         (shadow_save_op),
        .restore      (shadow_restore_op),
        .live         (shadow_live),
        .copy         (shadow_copy),
        .restore_valid(shadow_rvalid)
    );

    // -------------------------------------------------------------------------
    // arbitration: highest priority wins, lowest source number breaks ties
    // -------------------------------------------------------------------------
    always_comb begin
        arb_valid = 1'b0;
        arb_prio  = '0;
        arb_src   = '0;
        p         = '0;
        for (int i = 0; i < irq_seq_pkg::NUM_SRC; i++) begin
            p = src_priority[i*irq_seq_pkg::PRIO_W +: irq_seq_pkg::PRIO_W];
            if (cur.flags[i] && interrupt_enable_regs[i]
                && (!arb_valid || p > arb_prio)) begin
                arb_valid = 1'b1;
                arb_prio  = p;
                arb_src   = irq_seq_pkg::SRC_W'(i);
            end
        end
    end

    assign cur_level  = {cur.core_ctrl[irq_seq_pkg::CC_TRAP_BIT],
                         cur.sw[irq_seq_pkg::SW_IPL_LSB +: irq_seq_pkg::PRIO_W]};
    assign take_now   = cur.best_valid
                        && ({1'b0, cur.best_prio} > cur_level);
    assign table_base = alt_table_select ? irq_seq_pkg::ALT_TABLE_BASE
                                         : irq_seq_pkg::PRIMARY_TABLE_BASE;

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        next_cur              = cur;
        next_cur.push_valid   = 1'b0;
        next_cur.vec_valid    = 1'b0;
        next_cur.pc_rst_valid = 1'b0;

        // flags: a new event wins over a clear in the same cycle
        if (instr_cycle_start) begin
            next_cur.flags    = (cur.flags & ~flag_clear) | cur.ev_latch | events_all;
            next_cur.ev_latch = '0;
        end else begin
            next_cur.flags    = cur.flags & ~flag_clear;
            next_cur.ev_latch = cur.ev_latch | events_all;
        end

        next_cur.best_valid = arb_valid;
        next_cur.best_prio  = arb_prio;
        next_cur.best_src   = arb_src;
        next_cur.wake       = sleep_or_idle && take_now;

        // software writes; the sequence itself overrides below
        if (state_word_wr) begin
            next_cur.sw = state_word_wr_data;
        end
        if (core_ctrl_wr) begin
            next_cur.core_ctrl = core_ctrl_wr_data;
        end
        next_cur.core_ctrl[irq_seq_pkg::CC_TRAP_BIT] = trap_active;

        if (shadow_rvalid) begin
            next_cur.sw[irq_seq_pkg::SW_DC] = shadow_copy[68];
            next_cur.sw[irq_seq_pkg::SW_N]  = shadow_copy[67];
            next_cur.sw[irq_seq_pkg::SW_OV] = shadow_copy[66];
            next_cur.sw[irq_seq_pkg::SW_Z]  = shadow_copy[65];
            next_cur.sw[irq_seq_pkg::SW_C]  = shadow_copy[64];
        end

        unique case (cur.fsm)
            irq_seq_pkg::ST_IDLE: begin
                if (return_from_handler_op) begin
                    next_cur.fsm = irq_seq_pkg::ST_POP_HI;
                end else if (instr_cycle_start && take_now) begin
                    next_cur.fsm        = irq_seq_pkg::ST_PUSH_LO;
                    next_cur.take_prio  = cur.best_prio;
                    next_cur.take_src   = cur.best_src;
                    next_cur.push_valid = 1'b1;
                    next_cur.push_data  = pc_current[15:0];
                end
            end
            irq_seq_pkg::ST_PUSH_LO: begin
                next_cur.fsm        = irq_seq_pkg::ST_PUSH_HI;
                next_cur.push_valid = 1'b1;
                next_cur.push_data  = {cur.sw[irq_seq_pkg::SW_LOW_BYTE_W-1:0],
                                       cur.core_ctrl[irq_seq_pkg::CC_TRAP_BIT],
                                       pc_current[irq_seq_pkg::PC_W-1:16]};
            end
            irq_seq_pkg::ST_PUSH_HI: begin
                next_cur.fsm = irq_seq_pkg::ST_VECTOR;
                next_cur.sw[irq_seq_pkg::SW_IPL_LSB +: irq_seq_pkg::PRIO_W] =
                    cur.take_prio;
            end
            irq_seq_pkg::ST_VECTOR: begin
                next_cur.fsm       = irq_seq_pkg::ST_IDLE;
                next_cur.vec_valid = 1'b1;
                next_cur.vec_src   = cur.take_src;
                next_cur.vec_addr  = table_base
                    + irq_seq_pkg::PC_W'(cur.take_src) * irq_seq_pkg::VECTOR_STRIDE;
            end
            irq_seq_pkg::ST_POP_HI: begin
                if (stack_pop_valid) begin
                    next_cur.fsm       = irq_seq_pkg::ST_POP_LO;
                    next_cur.sw[irq_seq_pkg::SW_LOW_BYTE_W-1:0] = stack_pop_data[15:8];
                    next_cur.pop_pc_hi = stack_pop_data[irq_seq_pkg::PC_HI_W-1:0];
                end
            end
            irq_seq_pkg::ST_POP_LO: begin
                if (stack_pop_valid) begin
                    next_cur.fsm          = irq_seq_pkg::ST_IDLE;
                    next_cur.pc_rst_valid = 1'b1;
                    next_cur.pc_rst       = {cur.pop_pc_hi, stack_pop_data};
                end
            end
            default: begin
                next_cur.fsm = irq_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cur           <= '0;
            cur.fsm       <= irq_seq_pkg::ST_IDLE;
            cur.sw        <= irq_seq_pkg::STATE_WORD_RESET;
            cur.core_ctrl <= irq_seq_pkg::CORE_CTRL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign interrupt_flag_regs     = cur.flags;
    assign proc_state_word         = cur.sw;
    assign core_control_reg        = cur.core_ctrl;
    assign busy                    = (cur.fsm != irq_seq_pkg::ST_IDLE);
    assign wake_req                = cur.wake;
    assign stack_push_valid        = cur.push_valid;
    assign stack_push_data         = cur.push_data;
    assign stack_pop_req           = (cur.fsm == irq_seq_pkg::ST_POP_HI)
                                     || (cur.fsm == irq_seq_pkg::ST_POP_LO);
    assign vector_valid            = cur.vec_valid;
    assign vector_addr             = cur.vec_addr;
    assign vector_src              = cur.vec_src;
    assign pc_restore_valid        = cur.pc_rst_valid;
    assign pc_restore              = cur.pc_rst;
    assign work_regs_restore_valid = shadow_rvalid;
    assign work_regs_restore       = shadow_copy[irq_seq_pkg::WREG_W-1:0];
endmodule : cpu_interrupt_sequencer
`default_nettype wire

//--- irq_seq_pkg.sv
// constants, field positions and state codes of the interrupt sequencer
`default_nettype none
package irq_seq_pkg;
    // -------------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------------
    localparam int NUM_SRC   = 16;
    localparam int SRC_W     = 4;
    localparam int PRIO_W    = 3;
    localparam int LEVEL_W   = 4;
    localparam int PC_W      = 23;
    localparam int PC_HI_W   = 7;
    localparam int WORD_W    = 16;
    localparam int EXT_COUNT = 3;
    localparam int WREG_W    = 64;
    localparam int SHADOW_W  = 69;

    // -------------------------------------------------------------------------
    // state word and core control fields
    // -------------------------------------------------------------------------
    localparam logic [15:0] STATE_WORD_RESET = 16'h0000;
    localparam logic [15:0] CORE_CTRL_RESET  = 16'h0000;
    localparam int          SW_IPL_LSB       = 5;
    localparam int          SW_LOW_BYTE_W    = 8;
    localparam int          SW_DC            = 8;
    localparam int          SW_N             = 3;
    localparam int          SW_OV            = 2;
    localparam int          SW_Z             = 1;
    localparam int          SW_C             = 0;
    localparam int          CC_TRAP_BIT      = 3;

    // -------------------------------------------------------------------------
    // sources fed by the external inputs
    // -------------------------------------------------------------------------
    localparam int EXT_SRC_BASE = 0;

    // -------------------------------------------------------------------------
    // vector tables: the alternate table directly follows the primary one
    // -------------------------------------------------------------------------
    localparam logic [22:0] VECTOR_STRIDE      = 23'h000002;
    localparam logic [22:0] PRIMARY_TABLE_BASE = 23'h000014;
    localparam logic [22:0] TABLE_SPAN         = 23'h000020;
    localparam logic [22:0] ALT_TABLE_BASE     = PRIMARY_TABLE_BASE + TABLE_SPAN;

    // -------------------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PUSH_LO = 3'b001,
        ST_PUSH_HI = 3'b010,
        ST_VECTOR  = 3'b011,
        ST_POP_HI  = 3'b100,
        ST_POP_LO  = 3'b101
    } seq_state_t;
endpackage : irq_seq_pkg
`default_nettype wire

//--- ext_edge_detect.sv
// edge detector for one external interrupt input
`timescale 1ns/10ps
`default_nettype none
module ext_edge_detect (
    // clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // pin and polarity
    input  wire logic pin,
    input  wire logic falling_sel,
    // one-sample request
    output logic      edge_pulse
);
    typedef struct packed {
        logic sample;
        logic prev;
        logic pulse;
    } edge_t;

    edge_t cur;
    edge_t next_cur;

    always_comb begin
        next_cur        = cur;
        next_cur.sample = pin;
        next_cur.prev   = cur.sample;
        next_cur.pulse  = falling_sel ? (cur.prev & ~cur.sample)
                                      : (~cur.prev & cur.sample);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign edge_pulse = cur.pulse;
endmodule : ext_edge_detect
`default_nettype wire

//--- shadow_context.sv
// one-level shadow copy of the status flags and first four working registers
`timescale 1ns/10ps
`default_nettype none
module shadow_context (
    // clock and reset
    input  wire logic                             mclk,
    input  wire logic                             arst_n,
    // save and restore strobes
    input  wire logic                             save,
    input  wire logic                             restore,
    // live context in, shadow copy out
    input  wire logic [irq_seq_pkg::SHADOW_W-1:0] live,
    output logic      [irq_seq_pkg::SHADOW_W-1:0] copy,
    output logic                                  restore_valid
);
    typedef struct packed {
        logic [irq_seq_pkg::SHADOW_W-1:0] copy;
        logic                             rvalid;
    } shadow_t;

    shadow_t cur;
    shadow_t next_cur;

    always_comb begin
        next_cur        = cur;
        next_cur.rvalid = restore;
        if (save) begin
            next_cur.copy = live;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign copy          = cur.copy;
    assign restore_valid = cur.rvalid;
endmodule : shadow_context
`default_nettype wire

//--- cis_asserts.sv
// port assertions of the interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module cis_asserts (
    // inputs
    input wire logic        mclk, arst_n, instr_cycle_start, trap_active, sleep_or_idle,
    input wire logic        return_from_handler_op, alt_table_select,
    input wire logic [15:0] flag_clear,
    input wire logic [47:0] src_priority,
    // outputs
    input wire logic        wake_req, stack_push_valid, stack_pop_req, vector_valid,
    input wire logic [15:0] interrupt_flag_regs, proc_state_word, core_control_reg, stack_push_data,
    input wire logic [22:0] vector_addr,
    input wire logic [3:0]  vector_src
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_flag_hold:
        assert property (!instr_cycle_start && flag_clear == 16'h0000 |=> $stable(interrupt_flag_regs))
        else $error("flags moved off cycle start");
    a_push_pair:
        assert property ($rose(stack_push_valid) |=> stack_push_valid ##1 !stack_push_valid)
        else $error("stack frame not two words");
    a_push_frame:
        assert property (stack_push_valid && $past(stack_push_valid) |->
            stack_push_data[15:7] == {$past(proc_state_word[7:0]), 1'b0}) else $error("bad hi word");
    a_vector_time:
        assert property (stack_push_valid && $past(stack_push_valid) |-> ##2 vector_valid)
        else $error("vector late");
    a_vector_addr:
        assert property (vector_valid |-> vector_addr == (alt_table_select ?
            irq_seq_pkg::ALT_TABLE_BASE : irq_seq_pkg::PRIMARY_TABLE_BASE) + {vector_src, 1'b0})
        else $error("bad vector address");
    a_ipl_load:
        assert property (vector_valid |-> proc_state_word[7:5] == src_priority[vector_src*3 +: 3])
        else $error("priority not loaded");
    a_trap_copy:
        assert property (1'b1 |=> core_control_reg[3] == $past(trap_active))
        else $error("trap bit wrong");
    a_pop_start:
        assert property ($rose(stack_pop_req) |-> $past(return_from_handler_op))
        else $error("pop without return");
    a_wake_cause:
        assert property (wake_req |-> $past(sleep_or_idle)) else $error("wake while awake");
endmodule : cis_asserts
bind cpu_interrupt_sequencer cis_asserts asserts_u (.*);
`default_nettype wire

//--- core_stack_model.sv
// processor stack memory answering push and pop traffic
`timescale 1ns/10ps
`default_nettype none
module core_stack_model (
    // clock, reset and answer speed
    input wire logic        mclk, arst_n, slow,
    // stack traffic
    input wire logic        push_valid, pop_req,
    input wire logic [15:0] push_data,
    output logic            pop_valid,
    output logic [15:0]     pop_data
);
    logic [15:0] stk[$];
    int          wait_n;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stk.delete();
            wait_n = 0;
            pop_valid <= 1'b0;
            pop_data <= 16'h0000;
        end else begin
            pop_valid <= 1'b0;
            pop_data <= ~pop_data;
            if (push_valid) stk.push_back(push_data);
            if (pop_req && !pop_valid && stk.size() > 0) begin
                if (wait_n >= (slow ? 3 : 0)) begin
                    pop_valid <= 1'b1;
                    pop_data <= stk.pop_back();
                    wait_n = 0;
                end else wait_n++;
            end
        end
    end
endmodule : core_stack_model
`default_nettype wire

//--- cpu_interrupt_sequencer_tb.sv
// self-checking testbench of the interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_sequencer_tb;
    logic mclk = 0, arst_n = 0, instr_cycle_start = 0, alt_table_select = 0, slow = 0;
    logic state_word_wr = 0, core_ctrl_wr = 0, trap_active = 0, sleep_or_idle = 0;
    logic return_from_handler_op = 0, shadow_save_op = 0, shadow_restore_op = 0;
    logic [2:0]  ext_irq_inputs = 3'h0, ext_edge_select_bits = 3'h0;
    logic [15:0] periph_events = 16'h0, flag_clear = 16'h0, interrupt_enable_regs = 16'h0026;
    logic [15:0] state_word_wr_data = 16'h0, core_ctrl_wr_data = 16'h0;
    logic [47:0] src_priority = {30'h0, 3'd3, 3'd0, 3'd0, 3'd6, 3'd5, 3'd0};
    logic [22:0] pc_current = 23'h5a1234;
    logic [63:0] work_regs_live = 64'h0;
    logic        stack_pop_valid, busy, wake_req, stack_push_valid, stack_pop_req, vector_valid;
    logic        pc_restore_valid, work_regs_restore_valid;
    logic [15:0] stack_pop_data, interrupt_flag_regs, proc_state_word, core_control_reg;
    logic [15:0] stack_push_data, push_w[2];
    logic [22:0] vector_addr, pc_restore, v_addr, r_pc;
    logic [3:0]  vector_src, v_src;
    logic [63:0] work_regs_restore, r_regs;
    int nvec = 0, npush = 0, nrest = 0, nwake = 0, cyc = 0, miscompares = 0, comparisons = 0;

    cpu_interrupt_sequencer dut_u (.*);
    core_stack_model model_u (.mclk(mclk), .arst_n(arst_n), .slow(slow),
        .push_valid(stack_push_valid), .push_data(stack_push_data), .pop_req(stack_pop_req),
        .pop_valid(stack_pop_valid), .pop_data(stack_pop_data));

    always #2.5 mclk = ~mclk;
    // cycle start every fourth clock, plus output capture
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        instr_cycle_start <= (cyc % 4 == 3);
        if (stack_push_valid) push_w[npush % 2] = stack_push_data;
        if (stack_push_valid) npush++;
        if (vector_valid) v_addr = vector_addr;
        if (vector_valid) v_src = vector_src;
        if (vector_valid) nvec++;
        if (pc_restore_valid) r_pc = pc_restore;
        if (pc_restore_valid) nrest++;
        if (work_regs_restore_valid) r_regs = work_regs_restore;
        if (wake_req) nwake++;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wr_sw(input logic [15:0] d);
        state_word_wr <= 1'b1;
        state_word_wr_data <= d;
        tick(1);
        state_word_wr <= 1'b0;
        tick(1);
    endtask : wr_sw
    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    initial begin
        #20000;
        miscompares++;
        final_report();
    end

    initial begin
        tick(12);
        arst_n <= 1'b1;
        tick(1);
        chk(core_control_reg, 16'h0000);
        wr_sw(16'h0060);
        periph_events <= 16'h0020;
        tick(1);
        periph_events <= 16'h0000;
        tick(12);
        chk(interrupt_flag_regs[5], 1'b1);
        chk(npush, 0);
        wr_sw(16'h0020);
        for (int i = 0; i < 40 && nvec == 0; i++) tick(1);
        tick(2);
        chk(v_addr, irq_seq_pkg::PRIMARY_TABLE_BASE + 23'h00000a);
        chk(v_src, 4'h5);
        chk(proc_state_word[7:5], 3'd3);
        chk({push_w[1], push_w[0]}, 32'h205a1234);
        flag_clear <= 16'h0020;
        slow <= 1'b1;
        tick(1);
        flag_clear <= 16'h0000;
        return_from_handler_op <= 1'b1;
        tick(1);
        return_from_handler_op <= 1'b0;
        tick(1);
        chk(busy, 1'b1);
        for (int i = 0; i < 40 && nrest == 0; i++) tick(1);
        tick(1);
        chk(r_pc, 23'h5a1234);
        chk(proc_state_word[7:0], 8'h20);
        ext_edge_select_bits <= 3'b010;
        alt_table_select <= 1'b1;
        pc_current <= 23'h012345;
        ext_irq_inputs <= 3'b010;
        tick(12);
        chk(interrupt_flag_regs[1], 1'b0);
        ext_irq_inputs <= 3'b000;
        for (int i = 0; i < 40 && nvec == 1; i++) tick(1);
        tick(2);
        chk(v_addr, irq_seq_pkg::ALT_TABLE_BASE + 23'h000002);
        chk({push_w[1], push_w[0]}, 32'h20012345);
        flag_clear <= 16'h0002;
        tick(1);
        flag_clear <= 16'h0000;
        tick(12);
        chk(interrupt_flag_regs[1], 1'b0);
        trap_active <= 1'b1;
        tick(2);
        chk(core_control_reg[3], 1'b1);
        trap_active <= 1'b0;
        core_ctrl_wr <= 1'b1;
        core_ctrl_wr_data <= 16'h00f8;
        sleep_or_idle <= 1'b1;
        periph_events <= 16'h0004;
        tick(1);
        periph_events <= 16'h0000;
        core_ctrl_wr <= 1'b0;
        tick(16);
        chk(nwake > 0, 1'b1);
        chk(core_control_reg, 16'h00f0);
        sleep_or_idle <= 1'b0;
        flag_clear <= 16'hffff;
        tick(1);
        flag_clear <= 16'h0000;
        wr_sw(16'h010f);
        work_regs_live <= 64'h0123456789abcdef;
        shadow_save_op <= 1'b1;
        tick(1);
        shadow_save_op <= 1'b0;
        wr_sw(16'h0000);
        work_regs_live <= 64'h0;
        shadow_restore_op <= 1'b1;
        tick(1);
        shadow_restore_op <= 1'b0;
        tick(3);
        chk(r_regs, 64'h0123456789abcdef);
        chk(proc_state_word[8:0] & 9'h10f, 9'h10f);
        final_report();
    end
endmodule : cpu_interrupt_sequencer_tb
`default_nettype wire
